// ==== wake_reset_consts.vh ====
// Constants for the wake-up and reset state block
`ifndef WAKE_RESET_CONSTS_VH
`define WAKE_RESET_CONSTS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFF_CTRL            8'h00
`define OFF_IRQ_CONTROL     8'h04
`define OFF_PERIPH_FLAGS    8'h08
`define OFF_PC              8'h0C
`define OFF_STACK_TOP       8'h10
`define OFF_STACK_PTR       8'h14
`define OFF_PORT_LATCH      8'h18
`define OFF_PORT_DIR        8'h1C
`define OFF_PORT_PINS       8'h20
`define OFF_BUS_STATUS      8'h24
`define OFF_BUS_MIRROR_LO   8'h28
`define OFF_BUS_MIRROR_HI   8'h34
`define OFF_INT_STATUS      8'h38
`define OFF_INT_MASK        8'h3C

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define CTRL_SLEEP_BIT      8
`define HIGH_PRIO_EN_BIT    7
`define LOW_PRIO_EN_BIT     6
`define EXT_FLAG_BIT        1
`define IRQ_CONTROL_MASK    8'hC2
`define STACK_PTR_MASK      8'h9F
`define STACK_FULL_BIT      7
`define PORT_GATED_BIT      6
`define INT_WAKE_BIT        0
`define INT_VECTOR_BIT      1
`define INT_STACK_FULL_BIT  2
`define INT_BITS_MASK       8'h07

// ------------------------------------------------------------
// Modes, vectors and reset values
// ------------------------------------------------------------
`define EXT_CLOCK_IO_OSC_MODE 3'h5
`define RC_IO_OSC_MODE        3'h7
`define VEC_HIGH_PRIO       21'h000008
`define VEC_LOW_PRIO        21'h000018
`define PC_STEP             21'h000002
`define RST_CTRL            3'h0
`define RST_PORT_DIR        8'hFF
`define RST_BUS_STATUS      8'h80

`endif

// ==== wake_sync2.v ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module wake_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             mclk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] stage1;

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= {WIDTH{1'b0}};
      dout   <= {WIDTH{1'b0}};
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule // wake_sync2

`default_nettype wire

// ==== return_stack.v ====
// Hardware return stack with push pointer
`timescale 1ns/1ps
`default_nettype none

module return_stack #(
  parameter DEPTH = 31,
  parameter AW    = 5,
  parameter DW    = 21
) (
  input  wire          mclk,
  input  wire          resetn,
  input  wire          push,
  input  wire [DW-1:0] push_data,
  output reg  [AW-1:0] ptr,
  output reg           full
);

  reg [DW-1:0] mem [0:DEPTH];

  always @(posedge mclk) begin
    if (push && !full) begin
      mem[ptr] <= push_data;
    end
  end

  // ------------------------------------------------------------
  // Pointer moves to the next free entry
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ptr  <= {AW{1'b0}};
      full <= 1'b0;
    end else if (push && !full) begin
      ptr  <= ptr + {{(AW-1){1'b0}}, 1'b1};
      full <= ({{(32-AW){1'b0}}, ptr} == DEPTH - 1);
    end
  end

endmodule // return_stack

`default_nettype wire

// ==== wake_reset_state_rules.v ====
// Wake-up and reset register state sequencer with AHB-Lite register slave
// Notes on behaviour
// RULE1 - Interrupt wake with a global enable set loads PC with the vector.
// RULE2 - That wake copies the current PC into the three stack-top bytes.
// RULE3 - That wake advances the return stack pointer to the next entry; once the stack is full the pointer holds at 31.
// RULE4 - An external or peripheral interrupt wake-up sets flag bits in irq control or peripheral flags; a watchdog wake sets none.
// RULE5 - Port bit 6 works only in the two I/O oscillator modes, else zero.
// RULE6 - Bus controller status value also appears at its four read-only mirrors.
// RULE7 - Unimplemented register bits always read as zero.
// RULE8 - Watchdog or interrupt wake without vectoring resumes at PC plus two.
`include "wake_reset_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module wake_reset_state_rules #(
  parameter STACK_DEPTH = 31,
  parameter PC_W        = 21
) (
  input  wire        mclk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        ext_int_pin,
  input  wire [7:0]  periph_wake_req,
  input  wire        wdt_timeout,
  input  wire [7:0]  first_port_in,
  output reg  [7:0]  first_port_out,
  output reg  [7:0]  first_port_oe,
  output reg         sleeping,
  output reg  [20:0] pc_out,
  output reg         irq
);

  // ------------------------------------------------------------
  // States and functions
  // ------------------------------------------------------------
  localparam [1:0] ST_RUN   = 2'd0;
  localparam [1:0] ST_SLEEP = 2'd1;
  localparam [1:0] ST_WAKE  = 2'd2;

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr[7:2] == off[7:2]);
    end
  endfunction

  function [7:0] port_mask;
    input [2:0] mode;
    begin
      port_mask = 8'hFF;
      if (mode != `EXT_CLOCK_IO_OSC_MODE && mode != `RC_IO_OSC_MODE) begin
        port_mask[`PORT_GATED_BIT] = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  reg  [7:0]      addr_q;
  reg             addr_ok;
  reg             wr_pend;
  reg             rd_pend;
  reg  [2:0]      osc_mode;
  reg  [7:0]      irq_control_regs;
  reg  [7:0]      periph_irq_flag_regs;
  reg  [PC_W-1:0] pc;
  reg  [PC_W-1:0] stack_top;
  reg  [7:0]      first_port_latch;
  reg  [7:0]      first_port_direction;
  reg  [7:0]      bus_ctrl_status;
  reg  [7:0]      int_status;
  reg  [7:0]      int_mask;
  reg  [1:0]      state;
  reg             cause_int;
  reg             ext_prev;
  reg             wdt_prev;
  reg  [31:0]     next_rdata;
  reg  [7:0]      next_int_status;
  wire            ext_s;
  wire            wdt_s;
  wire [7:0]      periph_s;
  wire [7:0]      first_port_pins;
  wire [4:0]      return_stack_pointer;
  wire            stack_full;
  wire            accept;
  wire            wr_now;
  wire            ext_rise;
  wire            wdt_rise;
  wire            periph_any;
  wire            gie_any;
  wire            do_vector;
  wire            rd_int_clear;
  wire [7:0]      pmask;
  wire [7:0]      stack_ptr_view;

  // ------------------------------------------------------------
  // Pin synchronisers and return stack
  // ------------------------------------------------------------
  wake_sync2 #(.WIDTH(1)) u_sync_ext (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (ext_int_pin),
    .dout   (ext_s)
  );

  wake_sync2 #(.WIDTH(1)) u_sync_wdt (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (wdt_timeout),
    .dout   (wdt_s)
  );

  wake_sync2 #(.WIDTH(8)) u_sync_periph (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (periph_wake_req),
    .dout   (periph_s)
  );

  wake_sync2 #(.WIDTH(8)) u_sync_port (
    .mclk   (mclk),
    .resetn (resetn),
    .din    (first_port_in),
    .dout   (first_port_pins)
  );

  return_stack #(.DEPTH(STACK_DEPTH), .AW(5), .DW(PC_W)) u_stack (
    .mclk      (mclk),
    .resetn    (resetn),
    .push      (do_vector), // [RULE3]
    .push_data (pc),
    .ptr       (return_stack_pointer),
    .full      (stack_full)
  );

  // ------------------------------------------------------------
  // Event decode
  // ------------------------------------------------------------
  assign accept       = hsel && htrans[1] && hready;
  assign wr_now       = wr_pend && addr_ok;
  assign ext_rise     = ext_s && !ext_prev;
  assign wdt_rise     = wdt_s && !wdt_prev;
  assign periph_any   = |periph_s;
  assign gie_any      = irq_control_regs[`HIGH_PRIO_EN_BIT] | irq_control_regs[`LOW_PRIO_EN_BIT];
  assign do_vector    = (state == ST_WAKE) && cause_int && gie_any; // [RULE1]
  assign rd_int_clear = rd_pend && addr_ok && hit(addr_q, `OFF_INT_STATUS);
  assign pmask        = port_mask(osc_mode); // [RULE5]
  assign stack_ptr_view = {stack_full, 2'b00, return_stack_pointer} & `STACK_PTR_MASK; // [RULE7]

  // ------------------------------------------------------------
  // AHB-Lite slave: writes zero wait, reads one wait
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      addr_q    <= 8'h00;
      addr_ok   <= 1'b0;
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h00000000;
      hresp     <= 1'b0;
    end else begin
      hresp   <= 1'b0;
      wr_pend <= accept && hwrite;
      if (accept) begin
        addr_q  <= haddr[7:0];
        addr_ok <= (haddr[31:8] == 24'h000000);
      end
      if (accept && !hwrite) begin
        rd_pend   <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_pend) begin
        rd_pend   <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Read multiplexer
  // ------------------------------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    if (addr_ok) begin
      if (hit(addr_q, `OFF_CTRL)) begin
        next_rdata = {23'h000000, sleeping, 5'h00, osc_mode};
      end else if (hit(addr_q, `OFF_IRQ_CONTROL)) begin
        next_rdata = {24'h000000, irq_control_regs & `IRQ_CONTROL_MASK}; // [RULE7]
      end else if (hit(addr_q, `OFF_PERIPH_FLAGS)) begin
        next_rdata = {24'h000000, periph_irq_flag_regs};
      end else if (hit(addr_q, `OFF_PC)) begin
        next_rdata = {11'h000, pc};
      end else if (hit(addr_q, `OFF_STACK_TOP)) begin
        next_rdata = {11'h000, stack_top};
      end else if (hit(addr_q, `OFF_STACK_PTR)) begin
        next_rdata = {24'h000000, stack_ptr_view};
      end else if (hit(addr_q, `OFF_PORT_LATCH)) begin
        next_rdata = {24'h000000, first_port_latch & pmask}; // [RULE5]
      end else if (hit(addr_q, `OFF_PORT_DIR)) begin
        next_rdata = {24'h000000, first_port_direction & pmask}; // [RULE5]
      end else if (hit(addr_q, `OFF_PORT_PINS)) begin
        next_rdata = {24'h000000, first_port_pins & pmask}; // [RULE5]
      end else if (addr_q >= `OFF_BUS_STATUS && addr_q <= `OFF_BUS_MIRROR_HI + 8'h03) begin
        next_rdata = {24'h000000, bus_ctrl_status}; // [RULE6]
      end else if (hit(addr_q, `OFF_INT_STATUS)) begin
        next_rdata = {24'h000000, int_status & `INT_BITS_MASK}; // [RULE7]
      end else if (hit(addr_q, `OFF_INT_MASK)) begin
        next_rdata = {24'h000000, int_mask & `INT_BITS_MASK}; // [RULE7]
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      osc_mode             <= `RST_CTRL;
      first_port_latch     <= 8'h00;
      first_port_direction <= `RST_PORT_DIR;
      bus_ctrl_status      <= `RST_BUS_STATUS;
      int_mask             <= 8'h00;
    end else if (wr_now) begin
      if (hit(addr_q, `OFF_CTRL)) begin
        osc_mode <= hwdata[2:0];
      end
      if (hit(addr_q, `OFF_PORT_LATCH)) begin
        first_port_latch <= hwdata[7:0];
      end
      if (hit(addr_q, `OFF_PORT_DIR)) begin
        first_port_direction <= hwdata[7:0];
      end
      if (hit(addr_q, `OFF_BUS_STATUS)) begin
        bus_ctrl_status <= hwdata[7:0]; // [RULE6]
      end
      if (hit(addr_q, `OFF_INT_MASK)) begin
        int_mask <= hwdata[7:0] & `INT_BITS_MASK;
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupt flag registers, hardware set wins
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_control_regs     <= 8'h00;
      periph_irq_flag_regs <= 8'h00;
      ext_prev             <= 1'b0;
      wdt_prev             <= 1'b0;
    end else begin
      ext_prev <= ext_s;
      wdt_prev <= wdt_s;
      if (wr_now && hit(addr_q, `OFF_IRQ_CONTROL)) begin
        irq_control_regs <= (hwdata[7:0] & `IRQ_CONTROL_MASK) |
                            {6'h00, ext_rise, 1'b0}; // [RULE4]
      end else if (ext_rise) begin
        irq_control_regs[`EXT_FLAG_BIT] <= 1'b1; // [RULE4]
      end
      if (wr_now && hit(addr_q, `OFF_PERIPH_FLAGS)) begin
        periph_irq_flag_regs <= hwdata[7:0] | periph_s; // [RULE4]
      end else begin
        periph_irq_flag_regs <= periph_irq_flag_regs | periph_s; // [RULE4]
      end
    end
  end

  // ------------------------------------------------------------
  // Sleep and wake sequence
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_RUN;
      cause_int <= 1'b0;
      pc        <= {PC_W{1'b0}};
      stack_top <= {PC_W{1'b0}};
    end else begin
      case (state)
        ST_RUN: begin
          if (wr_now && hit(addr_q, `OFF_PC)) begin
            pc <= hwdata[PC_W-1:0];
          end
          if (wr_now && hit(addr_q, `OFF_CTRL) && hwdata[`CTRL_SLEEP_BIT]) begin
            state <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (ext_rise || periph_any) begin
            cause_int <= 1'b1;
            state     <= ST_WAKE;
          end else if (wdt_rise) begin
            cause_int <= 1'b0;
            state     <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (do_vector) begin
            stack_top <= pc; // [RULE2]
            if (irq_control_regs[`HIGH_PRIO_EN_BIT]) begin
              pc <= `VEC_HIGH_PRIO; // [RULE1]
            end else begin
              pc <= `VEC_LOW_PRIO; // [RULE1]
            end
          end else begin
            pc <= pc + `PC_STEP; // [RULE8]
          end
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end
  // Stack pointer advance happens in u_stack on do_vector [RULE3]

  // ------------------------------------------------------------
  // Status register, read clears, set wins
  // ------------------------------------------------------------
  always @* begin
    next_int_status = int_status;
    if (rd_int_clear) begin
      next_int_status = 8'h00;
    end
    if (state == ST_WAKE) begin
      next_int_status[`INT_WAKE_BIT] = 1'b1;
    end
    if (do_vector) begin
      next_int_status[`INT_VECTOR_BIT] = 1'b1;
    end
    if (do_vector && stack_full) begin
      next_int_status[`INT_STACK_FULL_BIT] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      int_status     <= 8'h00;
      irq            <= 1'b0;
      first_port_out <= 8'h00;
      first_port_oe  <= 8'h00;
      sleeping       <= 1'b0;
      pc_out         <= 21'h000000;
    end else begin
      int_status     <= next_int_status;
      irq            <= |(next_int_status & int_mask);
      first_port_out <= first_port_latch & pmask; // [RULE5]
      first_port_oe  <= ~first_port_direction & pmask; // [RULE5]
      sleeping       <= (state == ST_SLEEP);
      pc_out         <= pc;
    end
  end

endmodule // wake_reset_state_rules

`default_nettype wire

// ==== wake_reset_checker.sv ====
// Assertion checker for the wake-up and reset state block
`timescale 1ns/1ps
`default_nettype none
module wake_reset_checker (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        wdt_timeout,
  input wire logic [7:0]  first_port_out,
  input wire logic [7:0]  first_port_oe,
  input wire logic        sleeping,
  input wire logic [20:0] pc_out
);
  // ----
  // Helper state
  // ----
  logic        ctrl_wr;
  logic [2:0]  osc_mode;
  logic        gate_open_d;
  logic [20:0] sleep_pc;
  wire         take      = hsel && htrans[1] && hready;
  wire         unmapped  = (haddr[31:8] != 24'h0) || (haddr[7:0] > 8'h3C);
  wire         gate_open = (osc_mode == 3'h5) || (osc_mode == 3'h7);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_wr <= 1'b0;
      osc_mode <= 3'h0;
      gate_open_d <= 1'b0;
      sleep_pc <= 21'h0;
    end else begin
      ctrl_wr <= take && hwrite && (haddr == 32'h0);
      if (ctrl_wr)
        osc_mode <= hwdata[2:0];
      gate_open_d <= gate_open;
      if (sleeping)
        sleep_pc <= pc_out;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_okay_resp: assert property (hresp == 1'b0) else $error("response not OKAY");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_unmapped_zero: assert property (
    take && !hwrite && unmapped |-> ##2 hreadyout && hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_port_bit6: assert property (
    !gate_open && !gate_open_d |-> !first_port_out[6] && !first_port_oe[6])
    else $error("port bit 6 active in gated mode");
  a_wake_pc: assert property (
    $fell(sleeping) |-> ##[0:3] (pc_out == 21'h000008 || pc_out == 21'h000018
      || pc_out == sleep_pc + 21'h000002))
    else $error("wake pc wrong");
  a_pc_hold_sleep: assert property (
    sleeping && $past(sleeping) |-> $stable(pc_out))
    else $error("pc moved in sleep");
  a_wdt_wake: assert property (
    sleeping && $rose(wdt_timeout) |-> ##[1:8] !sleeping)
    else $error("watchdog did not wake");
endmodule // wake_reset_checker

bind wake_reset_state_rules wake_reset_checker u_chk (
  .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .wdt_timeout(wdt_timeout),
  .first_port_out(first_port_out), .first_port_oe(first_port_oe),
  .sleeping(sleeping), .pc_out(pc_out));
`default_nettype wire

// ==== tb_wake_reset_state_rules.sv ====
// Testbench for the wake-up and reset state block
`include "wake_reset_consts.vh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); end end
module tb_wake_reset_state_rules;
  logic        mclk, resetn, hsel, hwrite, hreadyout, hresp, ext_int_pin;
  logic        wdt_timeout, sleeping, irq;
  logic [31:0] haddr, hwdata, hrdata, junk;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  periph_wake_req, first_port_in, first_port_out, first_port_oe;
  logic [20:0] pc_out;
  int          err_count, checks_done;
  wake_reset_state_rules dut (
    .mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_int_pin(ext_int_pin), .periph_wake_req(periph_wake_req),
    .wdt_timeout(wdt_timeout), .first_port_in(first_port_in),
    .first_port_out(first_port_out), .first_port_oe(first_port_oe),
    .sleeping(sleeping), .pc_out(pc_out), .irq(irq));
  always #5 mclk = ~mclk;
  // ----
  // Bus tasks
  // ----
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0, rd);
    `CHK(rd, exp)
  endtask
  task automatic do_wake(input int src, input logic [7:0] gie, input logic [20:0] pc0);
    wr32(`OFF_IRQ_CONTROL, {24'h0, gie});
    wr32(`OFF_PC, {11'h0, pc0});
    wr32(`OFF_CTRL, 32'h00000100);
    for (int i = 0; i < 20 && sleeping !== 1'b1; i++) @(posedge mclk);
    `CHK(sleeping, 1'b1)
    if (src == 0) ext_int_pin <= 1'b1;
    else if (src == 1) periph_wake_req <= 8'h04;
    else wdt_timeout <= 1'b1;
    for (int i = 0; i < 20 && sleeping !== 1'b0; i++) @(posedge mclk);
    `CHK(sleeping, 1'b0)
    ext_int_pin <= 1'b0;
    periph_wake_req <= 8'h00;
    wdt_timeout <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset_values;
    logic [7:0]  offs [17] = '{`OFF_CTRL, `OFF_IRQ_CONTROL, `OFF_PERIPH_FLAGS, `OFF_PC,
      `OFF_STACK_TOP, `OFF_STACK_PTR, `OFF_PORT_LATCH, `OFF_PORT_DIR, `OFF_PORT_PINS,
      `OFF_BUS_STATUS, 8'h28, 8'h2C, 8'h30, 8'h34, `OFF_INT_STATUS, `OFF_INT_MASK, 8'h40};
    logic [31:0] exps [17] = '{0, 0, 0, 0, 0, 0, 0, 32'hBF, 32'hBF, 32'h80, 32'h80,
      32'h80, 32'h80, 32'h80, 0, 0, 0};
    for (int i = 0; i < 17; i++) rd_chk(offs[i], exps[i]);
    `CHK(irq, 1'b0)
  endtask
  task automatic t_port_modes;
    logic [2:0] md [4] = '{3'h0, 3'h5, 3'h7, 3'h3};
    logic [7:0] exp;
    for (int i = 0; i < 4; i++) begin
      wr32(`OFF_CTRL, {29'h0, md[i]});
      wr32(`OFF_PORT_LATCH, 32'hFF);
      wr32(`OFF_PORT_DIR, 32'h00);
      repeat (3) @(posedge mclk);
      exp = (md[i] == 3'h5 || md[i] == 3'h7) ? 8'hFF : 8'hBF;
      `CHK(first_port_out, exp)
      `CHK(first_port_oe, exp)
      rd_chk(`OFF_PORT_LATCH, {24'h0, exp});
      rd_chk(`OFF_PORT_PINS, {24'h0, exp});
      wr32(`OFF_PORT_DIR, 32'hFFFFFFFF);
      rd_chk(`OFF_PORT_DIR, {24'h0, exp});
    end
    wr32(`OFF_CTRL, 32'h0);
  endtask
  task automatic t_mirrors;
    wr32(`OFF_BUS_STATUS, 32'hFFFFFF5A);
    wr32(8'h2C, 32'h11);
    for (int a = 8'h24; a <= 8'h34; a += 4) rd_chk(a[7:0], 32'h5A);
    wr32(`OFF_IRQ_CONTROL, 32'hFFFFFFFF);
    rd_chk(`OFF_IRQ_CONTROL, 32'hC2);
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h40, 32'h0);
  endtask
  task automatic t_wake_vec;
    wr32(`OFF_INT_MASK, 32'h1);
    do_wake(0, 8'h80, 21'h000100);
    `CHK(irq, 1'b1)
    rd_chk(`OFF_PC, 32'h8);
    rd_chk(`OFF_STACK_TOP, 32'h100);
    rd_chk(`OFF_STACK_PTR, 32'h1);
    rd_chk(`OFF_IRQ_CONTROL, 32'h82);
    rd_chk(`OFF_INT_STATUS, 32'h3);
    @(posedge mclk);
    `CHK(irq, 1'b0)
    rd_chk(`OFF_INT_STATUS, 32'h0);
    do_wake(1, 8'h40, 21'h000200);
    rd_chk(`OFF_PC, 32'h18);
    rd_chk(`OFF_STACK_TOP, 32'h200);
    rd_chk(`OFF_STACK_PTR, 32'h2);
    rd_chk(`OFF_PERIPH_FLAGS, 32'h04);
    wr32(`OFF_PERIPH_FLAGS, 32'h0);
    rd_chk(`OFF_INT_STATUS, 32'h3);
  endtask
  task automatic t_wake_plain;
    wr32(`OFF_INT_MASK, 32'h0);
    do_wake(2, 8'h00, 21'h000300);
    `CHK(irq, 1'b0)
    rd_chk(`OFF_PC, 32'h302);
    rd_chk(`OFF_STACK_PTR, 32'h2);
    rd_chk(`OFF_INT_STATUS, 32'h1);
    do_wake(0, 8'h00, 21'h000400);
    rd_chk(`OFF_PC, 32'h402);
    rd_chk(`OFF_IRQ_CONTROL, 32'h02);
    rd_chk(`OFF_STACK_TOP, 32'h200);
    for (int i = 0; i < 30; i++) do_wake(0, 8'h80, 21'h000500);
    rd_chk(`OFF_STACK_PTR, 32'h9F);
    rd_chk(`OFF_INT_STATUS, 32'h7);
  endtask
  // ----
  // Run control
  // ----
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    {hsel, hwrite, ext_int_pin, wdt_timeout} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    periph_wake_req = 8'h00;
    first_port_in = 8'hFF;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset_values();
    t_port_modes();
    t_mirrors();
    t_wake_vec();
    t_wake_plain();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    test_done();
  end
endmodule // tb_wake_reset_state_rules
`default_nettype wire
